// file: inc/subroutine_call_return_control_regs.vh
// Purpose: constants for the call and return sequencer
// Assumes: one time state per clock at 100 MHz
// Notes:   opcode patterns are compared under their masks
`ifndef SUBROUTINE_CALL_RETURN_CONTROL_REGS_VH
`define SUBROUTINE_CALL_RETURN_CONTROL_REGS_VH

`define ADDR_W        14
`define BYTE_W        8
`define STACK_N       8
`define SP_W          3
`define MAX_SAVED     3'h7
`define ADDR_RST      14'h0000

// Opcode masks and patterns
`define CALL_U_MASK   8'hC7
`define CALL_U_PAT    8'h46
`define CALL_C_MASK   8'hC7
`define CALL_C_PAT    8'h42
`define RET_U_MASK    8'hC7
`define RET_U_PAT     8'h07
`define RET_C_MASK    8'hC7
`define RET_C_PAT     8'h03

// Opcode fields
`define OP_SENSE      5
`define OP_CC_HI      4
`define OP_CC_LO      3
`define HI_BYTE_USED  6

// Condition field codes
`define CC_CARRY      2'h0
`define CC_ZERO       2'h1
`define CC_SIGN       2'h2
`define CC_PARITY     2'h3

// Machine cycle codes
`define MC_FETCH      2'h0
`define MC_READ1      2'h1
`define MC_READ2      2'h2

// Time state codes
`define TS_1          3'h1
`define TS_2          3'h2
`define TS_3          3'h3
`define TS_4          3'h4
`define TS_5          3'h5

`endif

// file: rtl/subroutine_call_return_control.v
// Purpose: sequence call and return instructions over an eight-entry
//          address stack whose top is the program counter
// Assumes: program memory answers combinationally; the byte at
//          mem_data_i is valid in the third time state of each cycle
//          flags come from logic on the same clock
// Notes:   one clock edge is one time state; other opcodes are not
//          executed, they only finish a three-state fetch
//          the stack is circular: an eighth nested call overwrites
//          the oldest return address and the depth count stops at 7
//          a return with nothing saved wraps the pointer silently
`timescale 1ns/100ps
`include "subroutine_call_return_control_regs.vh"

module subroutine_call_return_control (
	// Clock and reset
	input  wire                 clk_sys_i,
	input  wire                 rst_b_i,
	// Program memory
	output wire [`ADDR_W-1:0]   mem_addr_o,
	output wire                 mem_rd_o,
	input  wire [`BYTE_W-1:0]   mem_data_i,
	// Condition flags
	input  wire                 flag_carry_i,
	input  wire                 flag_zero_i,
	input  wire                 flag_sign_i,
	input  wire                 flag_parity_i,
	// Sequencer status
	output wire [1:0]           cycle_type_o,
	output wire [2:0]           time_state_o,
	output wire                 insn_done_o,
	output wire                 call_taken_o,
	output wire                 ret_taken_o,
	output wire                 unhandled_o,
	output wire [`ADDR_W-1:0]   pc_o,
	output wire [`SP_W-1:0]     saved_depth_o
);

	// Cycle and state registers
	reg  [1:0]          mc_q;
	reg  [1:0]          mc_d;
	reg  [2:0]          ts_q;
	reg  [2:0]          ts_d;
	reg  [`BYTE_W-1:0]  opcode_q;
	reg  [`BYTE_W-1:0]  lo_byte_q;
	reg  [`BYTE_W-1:0]  hi_byte_q;
	reg  [`SP_W-1:0]    sp_q;
	reg  [`SP_W-1:0]    sp_d;
	reg  [`SP_W-1:0]    depth_q;
	reg  [`SP_W-1:0]    depth_d;
	reg  [`ADDR_W-1:0]  pc_q;
	reg  [`ADDR_W-1:0]  pc_d;
	reg  [`ADDR_W-1:0]  stack_q [0:`STACK_N-1];

	// Stack write port
	reg                 wr_en;
	reg  [`SP_W-1:0]    wr_idx;
	reg  [`ADDR_W-1:0]  wr_val;

	// Decode
	wire [`ADDR_W-1:0]  pc;
	wire [`ADDR_W-1:0]  pc_inc;
	wire [`ADDR_W-1:0]  target;
	wire [`BYTE_W-1:0]  op_now;
	wire                is_call_u;
	wire                is_call_c;
	wire                is_ret_u;
	wire                is_ret_c;
	wire                is_call_now;
	wire                is_ret_now;
	reg                 flag_sel;
	reg                 flag_sel_now;
	wire                call_go;
	wire                ret_go_now;
	reg                 ret_go_q;
	wire                last_state;

	// Top entry of the stack is the program counter; a flip-flop copy
	// of it drives the address so memory never sees the read mux settle
	assign pc     = pc_q;
	assign pc_inc = pc + 14'h0001;

	// Bits six and seven of the high byte are dropped; the held copy is
	// used because the byte is no longer on the bus in the fifth state
	assign target = {hi_byte_q[`HI_BYTE_USED-1:0], lo_byte_q};

	// Opcode classes; the live byte is used during the fetch itself
	assign op_now     = mem_data_i;
	assign is_call_u  = (opcode_q & `CALL_U_MASK) == `CALL_U_PAT;
	assign is_call_c  = (opcode_q & `CALL_C_MASK) == `CALL_C_PAT;
	assign is_call_now = ((op_now & `CALL_U_MASK) == `CALL_U_PAT) |
	                     ((op_now & `CALL_C_MASK) == `CALL_C_PAT);
	assign is_ret_u   = (op_now & `RET_U_MASK) == `RET_U_PAT;
	assign is_ret_c   = (op_now & `RET_C_MASK) == `RET_C_PAT;
	assign is_ret_now = is_ret_u | is_ret_c;

	// Calls test flags at the high byte read, returns at the opcode read
	// Flag chosen by the stored opcode, for conditional calls
	always @* begin
		case (opcode_q[`OP_CC_HI:`OP_CC_LO])
			`CC_CARRY:  flag_sel = flag_carry_i;
			`CC_ZERO:   flag_sel = flag_zero_i;
			`CC_SIGN:   flag_sel = flag_sign_i;
			`CC_PARITY: flag_sel = flag_parity_i;
			default:    flag_sel = flag_carry_i;
		endcase
	end

	// Flag chosen by the byte being fetched, for conditional returns
	always @* begin
		case (op_now[`OP_CC_HI:`OP_CC_LO])
			`CC_CARRY:  flag_sel_now = flag_carry_i;
			`CC_ZERO:   flag_sel_now = flag_zero_i;
			`CC_SIGN:   flag_sel_now = flag_sign_i;
			`CC_PARITY: flag_sel_now = flag_parity_i;
			default:    flag_sel_now = flag_carry_i;
		endcase
	end

	// Taken when the flag equals the sense bit: clear or set variant
	// Unconditional forms ignore the field and are always taken
	assign call_go    = is_call_u |
	                    (is_call_c & (flag_sel == opcode_q[`OP_SENSE]));
	assign ret_go_now = is_ret_u |
	                    (is_ret_c & (flag_sel_now == op_now[`OP_SENSE]));

	// Next cycle and time state
	always @* begin
		mc_d = mc_q;
		ts_d = ts_q + 3'h1;
		case (mc_q)
			`MC_FETCH: begin
				// Only a taken return runs on into the fourth and fifth states
				if (ts_q == `TS_3) begin
					if (is_call_now) begin
						mc_d = `MC_READ1;
						ts_d = `TS_1;
					end else if (!ret_go_now) begin
						ts_d = `TS_1;
					end
				end else if (ts_q == `TS_5) begin
					ts_d = `TS_1;
				end
			end
			`MC_READ1: begin
				// Low address byte, then straight on to the high byte
				if (ts_q == `TS_3) begin
					mc_d = `MC_READ2;
					ts_d = `TS_1;
				end
			end
			`MC_READ2: begin
				// Failed condition skips the fourth and fifth states
				if ((ts_q == `TS_3 && !call_go) || ts_q == `TS_5) begin
					mc_d = `MC_FETCH;
					ts_d = `TS_1;
				end
			end
			default: begin
				mc_d = `MC_FETCH;
				ts_d = `TS_1;
			end
		endcase
	end

	// The last state is seen one state ahead through the next-state logic
	assign last_state = (mc_d == `MC_FETCH) && (ts_d == `TS_1);

	// Stack pointer, saved depth and stack write; the pointer wraps
	// freely while the depth count saturates at seven, so the depth
	// never claims more saved addresses than the stack can hold
	always @* begin
		sp_d    = sp_q;
		depth_d = depth_q;
		wr_en   = 1'b0;
		wr_idx  = sp_q;
		wr_val  = pc_inc;
		// Each byte read advances PC, so a call leaves PC past itself
		if (ts_q == `TS_3) begin
			wr_en = 1'b1;
		end
		if (mc_q == `MC_READ2 && ts_q == `TS_5) begin
			// Old PC stays in its slot as the saved return address
			sp_d   = sp_q + 3'h1;
			wr_en  = 1'b1;
			wr_idx = sp_q + 3'h1;
			wr_val = target;
			if (depth_q != `MAX_SAVED) begin
				depth_d = depth_q + 3'h1;
			end
		end
		if (mc_q == `MC_FETCH && ts_q == `TS_5 && ret_go_q) begin
			// Exposing the entry below makes it the new PC
			sp_d = sp_q - 3'h1;
			if (depth_q != 3'h0) begin
				depth_d = depth_q - 3'h1;
			end
		end
	end

	// Value on top of the stack after this edge; kept in a flip-flop so
	// the address leaves a register rather than the stack read mux
	always @* begin
		if (wr_en && wr_idx == sp_d) begin
			pc_d = wr_val;
		end else begin
			pc_d = stack_q[sp_d];
		end
	end

	// Sequencer registers; bytes are latched only at the end of a third
	// state, the one time the bus carries a valid read
	always @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			pc_q      <= `ADDR_RST;
			mc_q      <= `MC_FETCH;
			ts_q      <= `TS_1;
			opcode_q  <= 8'h00;
			lo_byte_q <= 8'h00;
			hi_byte_q <= 8'h00;
			sp_q      <= 3'h0;
			depth_q   <= 3'h0;
			ret_go_q  <= 1'b0;
		end else begin
			pc_q    <= pc_d;
			mc_q    <= mc_d;
			ts_q    <= ts_d;
			sp_q    <= sp_d;
			depth_q <= depth_d;
			if (ts_q == `TS_3) begin
				case (mc_q)
					`MC_FETCH: begin
						opcode_q <= op_now;
						ret_go_q <= ret_go_now;
					end
					`MC_READ1: lo_byte_q <= mem_data_i;
					`MC_READ2: hi_byte_q <= mem_data_i;
					default:   opcode_q  <= opcode_q;
				endcase
			end
		end
	end

	// One register per stack entry
	// Only the entry named by the write port changes on an edge
	genvar gi;
	generate
		for (gi = 0; gi < `STACK_N; gi = gi + 1) begin : g_entry
			always @(posedge clk_sys_i) begin
				if (!rst_b_i) begin
					stack_q[gi] <= `ADDR_RST;
				end else if (wr_en && wr_idx == gi) begin
					stack_q[gi] <= wr_val;
				end
			end
		end
	endgenerate

	// Status pulses mark the final time state of taken calls, taken returns and other opcodes
	// Call and return pulses fall in the state whose end edge moves the pointer
	reg call_pulse;
	reg ret_pulse;
	reg other_pulse;
	always @* begin
		call_pulse  = (mc_q == `MC_READ2) && (ts_q == `TS_5);
		ret_pulse   = (mc_q == `MC_FETCH) && (ts_q == `TS_5) && ret_go_q;
		other_pulse = (mc_q == `MC_FETCH) && (ts_q == `TS_3) &&
		              !is_ret_now && last_state;
	end

	// Memory side; the read strobe drops in the fourth and fifth states,
	// where no byte is taken
	assign mem_addr_o    = pc;
	assign mem_rd_o      = (ts_q != `TS_4) && (ts_q != `TS_5);

	// Sequencer status
	assign cycle_type_o  = mc_q;
	assign time_state_o  = ts_q;
	assign insn_done_o   = last_state;
	assign call_taken_o  = call_pulse;
	assign ret_taken_o   = ret_pulse;
	assign unhandled_o   = other_pulse;
	assign pc_o          = pc;
	assign saved_depth_o = depth_q;

endmodule

// file: dv/subroutine_call_return_control_properties.sv
// Purpose: timing and stack checks on the call and return sequencer
// Assumes: one time state per clock
// Notes:   address bytes and opcode captured in helper registers
`timescale 1ns/100ps
`include "subroutine_call_return_control_regs.vh"
module subroutine_call_return_control_properties (
	input wire       clk_sys_i,
	input wire       rst_b_i,
	input wire [7:0] mem_data_i,
	input wire       flag_carry_i,
	input wire       flag_zero_i,
	input wire       flag_sign_i,
	input wire       flag_parity_i,
	input wire [1:0] cycle_type_o,
	input wire [2:0] time_state_o,
	input wire       insn_done_o,
	input wire       call_taken_o,
	input wire       ret_taken_o,
	input wire       unhandled_o,
	input wire [13:0] pc_o,
	input wire [2:0] saved_depth_o
);
	reg [7:0]  op_q;
	reg [7:0]  lo_q;
	reg [7:0]  hi_q;
	wire [3:0] fl = {flag_parity_i, flag_sign_i, flag_zero_i, flag_carry_i};
	wire       known_op = ((mem_data_i & `CALL_U_MASK) == `CALL_U_PAT) ||
		((mem_data_i & `CALL_C_MASK) == `CALL_C_PAT) || ((mem_data_i & `RET_U_MASK) == `RET_U_PAT) ||
		((mem_data_i & `RET_C_MASK) == `RET_C_PAT);
	// Capture each byte in the state that reads it
	always @(posedge clk_sys_i) begin
		if (time_state_o == `TS_3) begin
			if (cycle_type_o == `MC_FETCH) op_q <= mem_data_i;
			if (cycle_type_o == `MC_READ1) lo_q <= mem_data_i;
			if (cycle_type_o == `MC_READ2) hi_q <= mem_data_i;
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	sequence fetch_t3; cycle_type_o == `MC_FETCH && time_state_o == `TS_3; endsequence
	sequence read2_t3; cycle_type_o == `MC_READ2 && time_state_o == `TS_3; endsequence
	call_target_a: assert property (call_taken_o |=> pc_o == {hi_q[5:0], lo_q})
		else $error("call target wrong");
	call_push_a: assert property (call_taken_o |=> saved_depth_o ==
		($past(saved_depth_o) == 3'h7 ? 3'h7 : $past(saved_depth_o) + 3'h1)) else $error("push depth");
	call_time_a: assert property (fetch_t3 ##0 ((mem_data_i & `CALL_U_MASK) == `CALL_U_PAT)
		|-> ##8 (call_taken_o && insn_done_o)) else $error("call length");
	ret_time_a: assert property (fetch_t3 ##0 ((mem_data_i & `RET_U_MASK) == `RET_U_PAT)
		|-> ##2 (ret_taken_o && insn_done_o)) else $error("return length");
	ret_pop_a: assert property (ret_taken_o && saved_depth_o != 3'h0
		|=> saved_depth_o == $past(saved_depth_o) - 3'h1) else $error("pop depth");
	call_skip_a: assert property (read2_t3 ##0 insn_done_o |=> pc_o == $past(pc_o) + 14'h1
		&& time_state_o == `TS_1 && cycle_type_o == `MC_FETCH) else $error("failed call");
	cond_call_a: assert property (read2_t3 ##0 ((op_q & `CALL_C_MASK) == `CALL_C_PAT)
		|-> insn_done_o == (fl[op_q[4:3]] != op_q[5])) else $error("call condition");
	cond_ret_a: assert property (fetch_t3 ##0 ((mem_data_i & `RET_C_MASK) == `RET_C_PAT)
		|-> insn_done_o == (fl[mem_data_i[4:3]] != mem_data_i[5])) else $error("return condition");
	other_step_a: assert property (fetch_t3 ##0 !known_op |-> unhandled_o && insn_done_o ##1
		pc_o == $past(pc_o) + 14'h1) else $error("other opcode");
endmodule

// file: dv/prog_memory.sv
// Purpose: program memory answering the sequencer without wait states
// Assumes: bench loads the array by hierarchical reference
// Notes:   outside read states the byte is inverted so stale samples fail
`timescale 1ns/100ps
module prog_memory (
	input  wire [13:0] addr_i,
	input  wire        rd_i,
	output wire [7:0]  data_o
);
	reg [7:0] mem [0:16383];
	// Combinational answer in read states only
	assign data_o = rd_i ? mem[addr_i] : ~mem[addr_i];
endmodule

// file: dv/tb.sv
// Purpose: self-checking bench for the call and return sequencer
// Assumes: instructions start at a falling edge in time state 1
// Notes:   state counts and next address checked per instruction
`timescale 1ns/100ps
`include "subroutine_call_return_control_regs.vh"
module tb;
	reg         clk_sys_i = 1'b0;
	reg         rst_b_i = 1'b0;
	reg  [3:0]  flg = 4'h0;
	reg  [13:0] pc;
	wire [13:0] addr;
	wire [13:0] pc_o;
	wire [7:0]  data;
	wire        rd;
	wire        insn_done_o;
	wire [2:0]  saved_depth_o;
	integer     error_cnt = 0;
	integer     checks = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	subroutine_call_return_control subroutine_call_return_control_inst (.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i), .mem_addr_o(addr), .mem_rd_o(rd), .mem_data_i(data),
		.flag_carry_i(flg[0]), .flag_zero_i(flg[1]), .flag_sign_i(flg[2]), .flag_parity_i(flg[3]),
		.cycle_type_o(), .time_state_o(), .insn_done_o(insn_done_o), .call_taken_o(),
		.ret_taken_o(), .unhandled_o(), .pc_o(pc_o), .saved_depth_o(saved_depth_o));
	prog_memory prog_memory_inst (.addr_i(addr), .rd_i(rd), .data_o(data));
	task chk(input [15:0] seen, input [15:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				error_cnt = error_cnt + 1;
				$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task give_verdict;
		begin
			$display("mismatches %0d comparisons %0d", error_cnt, checks);
			if (error_cnt == 0 && checks > 0) $display("All tests passed");
			else $display("Some tests failed");
			$finish;
		end
	endtask
	task put(input [13:0] a, input [7:0] b0, input [7:0] b1, input [7:0] b2);
		begin
			prog_memory_inst.mem[a] = b0;
			prog_memory_inst.mem[a + 14'h1] = b1;
			prog_memory_inst.mem[a + 14'h2] = b2;
		end
	endtask
	// Count states up to completion; a runaway instruction ends the run
	task exec(input [3:0] n_exp, input [13:0] pc_exp);
		integer n;
		begin
			n = 1;
			while (insn_done_o !== 1'b1 && n < 12) begin
				@(negedge clk_sys_i);
				n = n + 1;
			end
			if (n == 12) begin
				error_cnt = error_cnt + 1;
				give_verdict;
			end
			@(negedge clk_sys_i);
			chk(n, n_exp);
			chk(pc_o, pc_exp);
			pc = pc_exp;
		end
	endtask
	// Don't-care bits set in both opcodes and in the ignored high bits
	task s_call_ret;
		begin
			put(pc, 8'hC0, 8'h00, 8'h00);
			exec(4'h3, 14'h0001);
			put(pc, 8'h7E, 8'h34, 8'hFF);
			exec(4'hB, 14'h3F34);
			chk(saved_depth_o, 16'h0001);
			put(14'h3F34, 8'h3F, 8'h00, 8'h00);
			exec(4'h5, 14'h0004);
		end
	endtask
	// Every field code, sense and flag level; other flags opposite
	task s_cond;
		integer i;
		reg [13:0] p;
		reg [13:0] t;
		begin
			for (i = 0; i < 16; i = i + 1) begin
				flg = {4{~i[0]}};
				flg[i[3:2]] = i[0];
				p = pc;
				t = 14'h1000 + {i[3:0], 4'h0};
				put(p, {2'h1, i[1], i[3:2], 3'h2}, t[7:0], {2'h3, t[13:8]});
				put(p + 14'h3, {2'h0, i[1], i[3:2], 3'h3}, 8'h00, 8'h00);
				put(t, {2'h0, i[1], i[3:2], 3'h3}, 8'h00, 8'h00);
				if (i[1] == i[0]) begin
					exec(4'hB, t);
					exec(4'h5, p + 14'h3);
				end else begin
					exec(4'h9, p + 14'h3);
					exec(4'h3, p + 14'h4);
				end
			end
		end
	endtask
	// Eight nested calls overwrite the oldest; seven returns unwind
	task s_nest;
		integer k;
		begin
			for (k = 0; k < 8; k = k + 1) begin
				put(pc, 8'h46, 8'h00, {2'h3, 6'h21 + k[5:0]});
				put({6'h21 + k[5:0], 8'h03}, 8'h07, 8'h07, 8'h07);
				exec(4'hB, {6'h21 + k[5:0], 8'h00});
			end
			chk(saved_depth_o, 16'h0007);
			put(pc, 8'h07, 8'h07, 8'h07);
			for (k = 7; k > 0; k = k - 1)
				exec(4'h5, {6'h20 + k[5:0], 8'h03});
			chk(saved_depth_o, 16'h0000);
		end
	endtask
	initial begin
		repeat (4) @(negedge clk_sys_i);
		rst_b_i = 1'b1;
		pc = 14'h0000;
		s_call_ret;
		s_cond;
		s_nest;
		give_verdict;
	end
endmodule
bind subroutine_call_return_control subroutine_call_return_control_properties chk_inst (
	.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .mem_data_i(mem_data_i),
	.flag_carry_i(flag_carry_i), .flag_zero_i(flag_zero_i), .flag_sign_i(flag_sign_i),
	.flag_parity_i(flag_parity_i), .cycle_type_o(cycle_type_o), .time_state_o(time_state_o),
	.insn_done_o(insn_done_o), .call_taken_o(call_taken_o), .ret_taken_o(ret_taken_o),
	.unhandled_o(unhandled_o), .pc_o(pc_o), .saved_depth_o(saved_depth_o));
